//--- agm_top.sv
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Address generator with circular correction and register slave
module agm_top (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // First-space request (read generator side)
  input wire logic req_i,
  input wire logic [2:0] mode_i,
  input wire logic [3:0] ptr_sel_i,
  input wire logic [15:0] ptr_val_i,
  input wire logic [15:0] ofs_val_i,
  input wire logic [15:0] lit_i,
  input wire logic byte_i,
  input wire logic write_i,
  input wire logic move_i,
  // Multiply-accumulate prefetch request
  input wire logic mac_req_i,
  input wire logic [1:0] mac_ptr_i,
  input wire logic [1:0] mac_mode_i,
  input wire logic [15:0] mac_ptr_val_i,
  input wire logic [15:0] mac_ofs_val_i,
  // Addresses out
  output logic first_valid_o,
  output logic [15:0] first_ea_o,
  output logic first_wb_o,
  output logic [3:0] first_wb_sel_o,
  output logic [15:0] first_wb_val_o,
  output logic second_valid_o,
  output logic [15:0] second_ea_o,
  output logic second_wb_o,
  output logic [1:0] second_wb_sel_o,
  output logic [15:0] second_wb_val_o,
  output logic mac_bad_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Software-visible state; nothing here changes unless the bus or the
  // sticky flag logic writes it, and a low clock enable holds all of it
  logic [15:0] control_q; // circular_addressing_control
  logic [15:0] first_start_q;
  logic [15:0] first_end_q;
  logic [15:0] second_start_q;
  logic [15:0] second_end_q;
  logic [15:0] bitrev_q; // Enable bit and pivot modifier
  logic mac_bad_q; // Sticky illegal prefetch form
  agm_pkg::agm_bus_e bus_q;
  logic wr_go; // Write takes effect this edge
  logic acc; // Request present
  logic [15:0] rd_val;

  // Request present on the bus
  assign acc = wb_cyc_i && wb_stb_i;
  // Write lands on the edge where the master samples ack, never earlier,
  // so a request dropped before its ack leaves the registers alone
  assign wr_go = acc && wb_we_i && wb_ack_o;

  // Ack one cycle after the request, then drop for one cycle
  // Idle takes a request; the ack state always returns to idle, so a
  // master that still holds cyc on the ack edge is not answered twice
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bus_q <= agm_pkg::AGM_BUS_IDLE;
    end else if (ce_i) begin
      case (bus_q)
        agm_pkg::AGM_BUS_IDLE: begin
          if (acc) begin
            bus_q <= agm_pkg::AGM_BUS_ACK;
          end
        end
        agm_pkg::AGM_BUS_ACK: begin
          bus_q <= agm_pkg::AGM_BUS_IDLE;
        end
        default: begin
          bus_q <= agm_pkg::AGM_BUS_IDLE;
        end
      endcase
    end
  end
  // Ack is masked while frozen, so the master never sees an answer
  // on an edge at which the registers cannot take the write
  assign wb_ack_o = ce_i && (bus_q == agm_pkg::AGM_BUS_ACK);

  // Register writes, low two byte lanes only
  // Upper lanes are ignored: every register here is 16 bits wide
  function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    lanes = old;
    if (s[0]) begin
      lanes[7:0] = d[7:0];
    end
    if (s[1]) begin
      lanes[15:8] = d[15:8];
    end
  endfunction : lanes

  // Control register
  // A new select or enable applies from the next address request onward
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      control_q <= agm_pkg::CONTROL_RST;
    end else if (wr_go && wb_adr_i == agm_pkg::ADR_CONTROL) begin
      control_q <= lanes(control_q, wb_dat_i, wb_sel_i);
    end
  end

  // Boundary and bit-reverse registers, 16 bits each; start even, end odd
  // Bit zero is stored as written but reads back fixed, so software sees
  // the word-aligned boundaries that the comparators are meant to use
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      first_start_q <= agm_pkg::BOUND_RST;
      first_end_q <= agm_pkg::BOUND_RST;
      second_start_q <= agm_pkg::BOUND_RST;
      second_end_q <= agm_pkg::BOUND_RST;
      bitrev_q <= agm_pkg::BOUND_RST;
    end else if (wr_go) begin
      case (wb_adr_i)
        agm_pkg::ADR_FIRST_START: first_start_q <= lanes(first_start_q, wb_dat_i, wb_sel_i);
        agm_pkg::ADR_FIRST_END: first_end_q <= lanes(first_end_q, wb_dat_i, wb_sel_i);
        agm_pkg::ADR_SECOND_START: second_start_q <= lanes(second_start_q, wb_dat_i, wb_sel_i);
        agm_pkg::ADR_SECOND_END: second_end_q <= lanes(second_end_q, wb_dat_i, wb_sel_i);
        agm_pkg::ADR_BITREV: bitrev_q <= lanes(bitrev_q, wb_dat_i, wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero but still ack
  // Latched when the request is taken; stands until the next access
  always_comb begin
    case (wb_adr_i)
      agm_pkg::ADR_CONTROL: rd_val = control_q;
      agm_pkg::ADR_FIRST_START: rd_val = {first_start_q[15:1], 1'b0};
      agm_pkg::ADR_FIRST_END: rd_val = {first_end_q[15:1], 1'b1};
      agm_pkg::ADR_SECOND_START: rd_val = {second_start_q[15:1], 1'b0};
      agm_pkg::ADR_SECOND_END: rd_val = {second_end_q[15:1], 1'b1};
      agm_pkg::ADR_BITREV: rd_val = bitrev_q;
      agm_pkg::ADR_STATUS: rd_val = {15'h0000, mac_bad_q};
      default: rd_val = 16'h0000;
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i && acc && bus_q == agm_pkg::AGM_BUS_IDLE) begin
      wb_dat_o <= {16'h0000, rd_val};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables
  // A select of 15 parks the field, so circular correction is off
  // whatever the enable bit says
  logic first_on; // First-space circular armed
  logic second_on; // Second-space circular armed
  logic brev_on;
  assign first_on = control_q[agm_pkg::CTL_FIRST_EN_BIT] &&
                    (control_q[agm_pkg::CTL_FIRST_SEL_LSB +: 4] != agm_pkg::SEL_NONE);
  assign second_on = control_q[agm_pkg::CTL_SECOND_EN_BIT] &&
                     (control_q[agm_pkg::CTL_SECOND_SEL_LSB +: 4] != agm_pkg::SEL_NONE);
  assign brev_on = bitrev_q[agm_pkg::BITREV_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // First-space generator: instruction operands and the first two prefetch pointers, W8 and W9
  agm_pkg::agm_mode_e fm;
  logic [15:0] f_base;
  logic [15:0] f_delta;
  logic f_pre;
  logic f_circ;
  logic f_wrback;
  logic [15:0] f_ea;
  logic [15:0] f_next;
  logic [15:0] f_step; // Size of one element
  logic mac_first; // Prefetch routed to first space
  logic [15:0] mac_step;
  logic mac_idx_ok;

  assign fm = agm_pkg::agm_mode_e'(mode_i);
  assign f_step = byte_i ? 16'h0001 : 16'h0002;
  assign mac_first = !mac_ptr_i[1];
  // Post-modify amounts of 2 and 4; indexed only on W9 and W11
  assign mac_step = {13'h0000, mac_mode_i, 1'b0};
  assign mac_idx_ok = mac_ptr_i[0];

  // Instruction request first; a first-space prefetch only when none is present
  // Defaults: pre-added sum, no write-back, zero modifier
  always_comb begin
    // Memory operand reached through a pointer register, except in the direct form
    f_base = ptr_val_i;
    f_delta = 16'h0000;
    f_pre = 1'b1;
    f_wrback = 1'b0;
    if (!req_i && mac_req_i && mac_first) begin
      // Prefetch post-modify uses the old pointer; indexed adds the offset
      f_base = mac_ptr_val_i;
      f_pre = 1'b0;
      f_wrback = (mac_mode_i != 2'b00) && (mac_mode_i != 2'b11);
      f_delta = (mac_mode_i == 2'b11) ? mac_ofs_val_i : mac_step;
      f_pre = (mac_mode_i == 2'b11);
    end else begin
      case (fm)
        agm_pkg::AGM_MODE_INDIRECT: f_pre = 1'b0;
        agm_pkg::AGM_MODE_POST: begin
          // Literal bit 15 picks the direction; the step is one element
          f_pre = 1'b0;
          f_wrback = 1'b1;
          f_delta = lit_i[15] ? 16'(-f_step) : f_step;
        end
        agm_pkg::AGM_MODE_PRE: begin
          f_wrback = 1'b1;
          f_delta = lit_i[15] ? 16'(-f_step) : f_step;
        end
        agm_pkg::AGM_MODE_INDEXED: f_delta = ofs_val_i;
        agm_pkg::AGM_MODE_LITOFS: f_delta = lit_i;
        agm_pkg::AGM_MODE_DIRECT: begin
          // Move reaches all of data space, others only the near region
          // Near region is the lowest 8192 bytes: upper three bits forced low
          f_base = move_i ? lit_i : {3'b000, lit_i[agm_pkg::NEAR_BITS-1:0]};
        end
        default: f_pre = 1'b0;
      endcase
    end
  end

  // Circular only on selected pointer; bit-reverse beats it for writes
  // Direct addresses never wrap: they are not formed from a pointer
  // An instruction write loses correction while bit-reverse is armed
  always_comb begin
    f_circ = first_on && (fm != agm_pkg::AGM_MODE_DIRECT || (!req_i && mac_req_i)) &&
             (req_i ? ptr_sel_i : {2'b10, mac_ptr_i}) ==
             control_q[agm_pkg::CTL_FIRST_SEL_LSB +: 4];
    if (req_i && write_i && brev_on) begin
      f_circ = 1'b0;
    end
  end

  agm_wrap u_first (
    .base_i(f_base),
    .delta_i(f_delta),
    .pre_i(f_pre),
    .circ_i(f_circ),
    .start_i(first_start_q),
    .end_i(first_end_q),
    // Byte data allowed here, so bit zero is left alone
    .word_i(1'b0),
    .ea_o(f_ea),
    .next_o(f_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Second-space generator: word reads from W10 and W11 only
  // Serves prefetch reads only; instruction requests never reach it
  // Pointer numbers 10 and 11 are formed by prefixing binary 10
  logic s_go;
  logic [15:0] s_delta;
  logic s_circ;
  logic [15:0] s_ea;
  logic [15:0] s_next;
  assign s_go = mac_req_i && !mac_first;
  assign s_delta = (mac_mode_i == 2'b11) ? mac_ofs_val_i : mac_step;
  assign s_circ = second_on && ({2'b10, mac_ptr_i} ==
                  control_q[agm_pkg::CTL_SECOND_SEL_LSB +: 4]);

  agm_wrap u_second (
    .base_i(mac_ptr_val_i),
    .delta_i(s_delta),
    .pre_i(mac_mode_i == 2'b11),
    .circ_i(s_circ),
    .start_i(second_start_q),
    .end_i(second_end_q),
    .word_i(1'b1),
    .ea_o(s_ea),
    .next_o(s_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; offset forms never write the pointer back
  // Each result stands one cycle; the consumer takes it at the next edge
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      first_valid_o <= 1'b0;
      first_ea_o <= 16'h0000;
      first_wb_o <= 1'b0;
      first_wb_sel_o <= 4'h0;
      first_wb_val_o <= 16'h0000;
    end else if (ce_i) begin
      first_valid_o <= req_i || (mac_req_i && mac_first);
      first_ea_o <= f_ea;
      // A second-space prefetch must not raise the first-space write-back
      first_wb_o <= f_wrback && (req_i || (mac_req_i && mac_first));
      first_wb_sel_o <= req_i ? ptr_sel_i : {2'b10, mac_ptr_i};
      first_wb_val_o <= f_next;
    end
  end

  // Second-space output registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      second_valid_o <= 1'b0;
      second_ea_o <= 16'h0000;
      second_wb_o <= 1'b0;
      second_wb_sel_o <= 2'b00;
      second_wb_val_o <= 16'h0000;
    end else if (ce_i) begin
      second_valid_o <= s_go;
      second_ea_o <= {s_ea[15:1], 1'b0};
      second_wb_o <= s_go && mac_mode_i != 2'b00 && mac_mode_i != 2'b11;
      second_wb_sel_o <= mac_ptr_i;
      second_wb_val_o <= s_next;
    end
  end

  // Sticky illegal-index flag; an indexed prefetch on the first or third
  // prefetch pointer has no legal meaning, so software is told of it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mac_bad_q <= 1'b0;
    end else if (ce_i) begin
      // Set wins over clear by write of the status word
      if (mac_req_i && mac_mode_i == 2'b11 && !mac_idx_ok) begin
        mac_bad_q <= 1'b1;
      end else if (wr_go && wb_adr_i == agm_pkg::ADR_STATUS && wb_sel_i[0] && wb_dat_i[0]) begin
        // Writing one to bit zero clears
        mac_bad_q <= 1'b0;
      end
    end
  end
  // Flag is visible as a pin as well as in the status word
  assign mac_bad_o = mac_bad_q;
endmodule : agm_top
`default_nettype wire

//--- agm_pkg.sv
package agm_pkg;
  // Register word addresses on the bus (byte addresses)
  localparam logic [7:0] ADR_CONTROL = 8'h00;
  localparam logic [7:0] ADR_FIRST_START = 8'h04;
  localparam logic [7:0] ADR_FIRST_END = 8'h08;
  localparam logic [7:0] ADR_SECOND_START = 8'h0C;
  localparam logic [7:0] ADR_SECOND_END = 8'h10;
  localparam logic [7:0] ADR_BITREV = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  // Control field positions
  localparam int CTL_FIRST_SEL_LSB = 0;
  localparam int CTL_SECOND_SEL_LSB = 4;
  localparam int CTL_SECOND_EN_BIT = 14;
  localparam int CTL_FIRST_EN_BIT = 15;
  localparam int BITREV_EN_BIT = 15;
  // Reset values and the select code that parks a field
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] BOUND_RST = 16'h0000;
  localparam logic [3:0] SEL_NONE = 4'hF;
  // Near data space limit of direct file-register form
  localparam int NEAR_BITS = 13;
  // Address modes
  typedef enum logic [2:0] {
    AGM_MODE_INDIRECT = 3'h0,
    AGM_MODE_POST = 3'h1,
    AGM_MODE_PRE = 3'h2,
    AGM_MODE_INDEXED = 3'h3,
    AGM_MODE_LITOFS = 3'h4,
    AGM_MODE_DIRECT = 3'h5
  } agm_mode_e;
  // Bus cycle states
  typedef enum logic [1:0] {
    AGM_BUS_IDLE = 2'b01,
    AGM_BUS_ACK = 2'b10
  } agm_bus_e;
endpackage : agm_pkg

//--- agm_wrap.sv
`timescale 1ns/10ps
`default_nettype none
// One address lane: adds the modifier and applies circular correction
module agm_wrap (
  // Operands
  input wire logic [15:0] base_i,
  input wire logic [15:0] delta_i,
  input wire logic pre_i,
  // Circular setup
  input wire logic circ_i,
  input wire logic [15:0] start_i,
  input wire logic [15:0] end_i,
  input wire logic word_i,
  // Results
  output logic [15:0] ea_o,
  output logic [15:0] next_o
);
  logic [15:0] sum; // Modified pointer
  logic [15:0] len; // Buffer length in bytes
  logic [15:0] fix; // Corrected pointer
  always_comb begin
    sum = base_i + delta_i;
    len = 16'(end_i - start_i + 16'h0001);
    fix = sum;
    if (circ_i) begin
      // Compare, not equality, so jumps past a bound still wrap
      if (!delta_i[15] && sum > end_i) begin
        fix = 16'(sum - len);
      end else if (delta_i[15] && sum < start_i) begin
        fix = 16'(sum + len);
      end
      if (word_i) begin
        fix[0] = 1'b0;
      end
    end
    next_o = fix;
    // Pre-modify and offset forms use the corrected sum; post uses the base
    ea_o = pre_i ? fix : base_i;
  end
endmodule : agm_wrap
`default_nettype wire

//--- agm_props.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checker for the address generator
module agm_props (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Requests
  input wire logic req_i,
  input wire logic [2:0] mode_i,
  input wire logic [15:0] ptr_val_i,
  input wire logic move_i,
  input wire logic mac_req_i,
  input wire logic [1:0] mac_ptr_i,
  input wire logic [1:0] mac_mode_i,
  // Results
  input wire logic first_valid_o,
  input wire logic [15:0] first_ea_o,
  input wire logic first_wb_o,
  input wire logic second_valid_o,
  input wire logic [15:0] second_ea_o,
  input wire logic mac_bad_o
);
  // One domain, so one clock and one disable
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_NEXT: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_HIGH_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_INDIRECT: assert property (ce_i && req_i && mode_i == 3'h0 |=> first_ea_o == $past(ptr_val_i))
    else $error("indirect address differs from pointer");
  AST_NO_WB_OFS: assert property (ce_i && req_i && mode_i inside {3'h3, 3'h4} |=> first_valid_o && !first_wb_o)
    else $error("offset mode wrote pointer back");
  AST_NEAR: assert property (ce_i && req_i && mode_i == 3'h5 && !move_i |=> first_ea_o[15:13] == 3'h0)
    else $error("direct address beyond near space");
  AST_ROUTE_X: assert property (ce_i && mac_req_i && !mac_ptr_i[1] && !req_i |=> first_valid_o && !second_valid_o)
    else $error("low prefetch pointer not in first space");
  AST_ROUTE_Y: assert property (ce_i && mac_req_i && mac_ptr_i[1] && !req_i |=> second_valid_o)
    else $error("high prefetch pointer not in second space");
  AST_WORD_Y: assert property (second_valid_o |-> !second_ea_o[0])
    else $error("second space address odd");
  AST_BAD_IDX: assert property (ce_i && mac_req_i && mac_mode_i == 2'h3 && !mac_ptr_i[0] |=> mac_bad_o)
    else $error("illegal indexed prefetch not flagged");
endmodule : agm_props
`default_nettype wire

//--- address_generator_modulo_test.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the address generator
module address_generator_modulo_test;
  logic mclk_i, rst_n_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, ptr_sel_i, first_wb_sel_o;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic req_i, byte_i, write_i, move_i, mac_req_i;
  logic [2:0] mode_i;
  logic [15:0] ptr_val_i, ofs_val_i, lit_i, mac_ptr_val_i, mac_ofs_val_i;
  logic [1:0] mac_ptr_i, mac_mode_i, second_wb_sel_o;
  logic first_valid_o, first_wb_o, second_valid_o, second_wb_o, mac_bad_o;
  logic [15:0] first_ea_o, first_wb_val_o, second_ea_o, second_wb_val_o;
  int fails, comparisons;
  agm_top u_agm_top (.mclk_i, .rst_n_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_i, .mode_i, .ptr_sel_i, .ptr_val_i,
    .ofs_val_i, .lit_i, .byte_i, .write_i, .move_i, .mac_req_i, .mac_ptr_i, .mac_mode_i,
    .mac_ptr_val_i, .mac_ofs_val_i, .first_valid_o, .first_ea_o, .first_wb_o,
    .first_wb_sel_o, .first_wb_val_o, .second_valid_o, .second_ea_o, .second_wb_o,
    .second_wb_sel_o, .second_wb_val_o, .mac_bad_o);
  // Free-running core clock
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Classic bus cycle; held until ack is sampled, bounded wait
  task automatic wbx(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'h3;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("BAD %0t no ack from register bus", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wbx
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    wbx(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
  endtask : rdc
  // Address request; write-back expected only in modify modes
  task automatic ec(input logic [2:0] m, input logic [3:0] s, input logic [15:0] p,
      input logic [15:0] l, input logic [1:0] f, input logic [15:0] e, input logic [15:0] v);
    @(posedge mclk_i);
    req_i <= 1'b1;
    mode_i <= m;
    ptr_sel_i <= s;
    ptr_val_i <= p;
    lit_i <= l;
    {write_i, move_i} <= f;
    @(posedge mclk_i);
    req_i <= 1'b0;
    @(posedge mclk_i);
    chk(first_ea_o, e);
    chk(first_wb_o, m inside {3'h1, 3'h2});
    if (m inside {3'h1, 3'h2}) chk({first_wb_sel_o, first_wb_val_o}, {s, v});
  endtask : ec
  task automatic mc(input logic [1:0] p, input logic [1:0] m, input logic [15:0] v);
    @(posedge mclk_i);
    mac_req_i <= 1'b1;
    mac_ptr_i <= p;
    mac_mode_i <= m;
    mac_ptr_val_i <= v;
    @(posedge mclk_i);
    mac_req_i <= 1'b0;
    @(posedge mclk_i);
  endtask : mc
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    rdc(agm_pkg::ADR_CONTROL, 16'h0000);
    rdc(agm_pkg::ADR_FIRST_START, 16'h0000);
    rdc(8'h1C, 16'h0000);
    ec(3'h0, 4'h1, 16'h1234, 16'h0000, 2'h0, 16'h1234, 16'h0000);
    ec(3'h1, 4'h1, 16'h1234, 16'h0000, 2'h0, 16'h1234, 16'h1236);
    ec(3'h1, 4'h2, 16'h1234, 16'h8000, 2'h0, 16'h1234, 16'h1232);
    ec(3'h2, 4'h3, 16'h1234, 16'h0000, 2'h0, 16'h1236, 16'h1236);
    byte_i <= 1'b1;
    ec(3'h1, 4'h1, 16'h1234, 16'h0000, 2'h0, 16'h1234, 16'h1235);
    byte_i <= 1'b0;
    ec(3'h3, 4'h4, 16'h122E, 16'h0000, 2'h0, 16'h1234, 16'h0000);
    ec(3'h4, 4'h4, 16'h1000, 16'h0034, 2'h0, 16'h1034, 16'h0000);
    ec(3'h5, 4'h0, 16'h0000, 16'hFFFF, 2'h0, 16'h1FFF, 16'h0000);
    ec(3'h5, 4'h0, 16'h0000, 16'hFFFF, 2'h1, 16'hFFFF, 16'h0000);
    $display("done modes");
  endtask : t_modes
  // First-space ring 0x1000..0x100F, sixteen bytes
  task automatic t_circ;
    wbx(1'b1, agm_pkg::ADR_FIRST_START, 16'h1000);
    wbx(1'b1, agm_pkg::ADR_FIRST_END, 16'h100F);
    wbx(1'b1, agm_pkg::ADR_CONTROL, 16'h8005);
    rdc(agm_pkg::ADR_CONTROL, 16'h8005);
    ec(3'h1, 4'h5, 16'h100E, 16'h0000, 2'h0, 16'h100E, 16'h1000);
    ec(3'h2, 4'h5, 16'h1000, 16'h8000, 2'h0, 16'h100E, 16'h100E);
    ec(3'h4, 4'h5, 16'h100E, 16'h0006, 2'h0, 16'h1004, 16'h0000);
    ec(3'h1, 4'h6, 16'h100E, 16'h0000, 2'h0, 16'h100E, 16'h1010);
    wbx(1'b1, agm_pkg::ADR_BITREV, 16'h8000);
    ec(3'h1, 4'h5, 16'h100E, 16'h0000, 2'h2, 16'h100E, 16'h1010);
    ec(3'h1, 4'h5, 16'h100E, 16'h0000, 2'h0, 16'h100E, 16'h1000);
    wbx(1'b1, agm_pkg::ADR_BITREV, 16'h0000);
    wbx(1'b1, agm_pkg::ADR_CONTROL, 16'h800F);
    ec(3'h1, 4'hF, 16'h100E, 16'h0000, 2'h0, 16'h100E, 16'h1010);
    wbx(1'b1, agm_pkg::ADR_CONTROL, 16'h0005);
    ec(3'h1, 4'h5, 16'h100E, 16'h0000, 2'h0, 16'h100E, 16'h1010);
    $display("done circ");
  endtask : t_circ
  // Prefetch routing, steps, illegal index, second-space ring
  task automatic t_mac;
    mc(2'h0, 2'h0, 16'h0900);
    chk({first_valid_o, second_valid_o, first_ea_o}, {2'b10, 16'h0900});
    mac_ofs_val_i <= 16'h0010;
    mc(2'h1, 2'h3, 16'h0800);
    chk({first_ea_o, mac_bad_o}, {16'h0810, 1'b0});
    mc(2'h3, 2'h2, 16'h2100);
    chk({second_valid_o, second_wb_o, second_wb_val_o}, {2'b11, 16'h2104});
    chk({first_valid_o, first_wb_o}, 2'b00);
    mc(2'h0, 2'h3, 16'h0900);
    chk(mac_bad_o, 1'b1);
    wbx(1'b1, agm_pkg::ADR_STATUS, 16'h0001);
    @(posedge mclk_i);
    chk(mac_bad_o, 1'b0);
    wbx(1'b1, agm_pkg::ADR_SECOND_START, 16'h2000);
    wbx(1'b1, agm_pkg::ADR_SECOND_END, 16'h2007);
    wbx(1'b1, agm_pkg::ADR_CONTROL, 16'h40AF);
    mc(2'h2, 2'h1, 16'h2006);
    chk({second_ea_o, second_wb_sel_o, second_wb_val_o}, {16'h2006, 2'h2, 16'h2000});
    // A frozen core must ignore a prefetch that would raise the flag
    ce_i <= 1'b0;
    mc(2'h0, 2'h3, 16'h0A00);
    chk({first_valid_o, mac_bad_o}, 2'b00);
    ce_i <= 1'b1;
    $display("done mac");
  endtask : t_mac
  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // Generous bound on the whole run
  initial begin
    repeat (5000) @(posedge mclk_i);
    fails++;
    final_report();
  end
  initial begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, req_i, byte_i, write_i, move_i, mac_req_i} = 9'h000;
    {wb_adr_i, wb_dat_i, mode_i, ptr_sel_i, mac_ptr_i, mac_mode_i} = 51'h0;
    {ptr_val_i, lit_i, mac_ptr_val_i, mac_ofs_val_i} = 64'h0;
    ofs_val_i = 16'h0006;
    wb_sel_i = 4'h3;
    ce_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_modes();
    t_circ();
    t_mac();
    final_report();
  end
endmodule : address_generator_modulo_test
bind agm_top agm_props u_agm_props (.mclk_i, .rst_n_i, .ce_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .req_i, .mode_i, .ptr_val_i, .move_i,
  .mac_req_i, .mac_ptr_i, .mac_mode_i, .first_valid_o, .first_ea_o, .first_wb_o,
  .second_valid_o, .second_ea_o, .mac_bad_o);
`default_nettype wire
